// ===== inc/lpsi_defs.vh
// timing, command and geometry constants for the low-power sdram init/access block
`ifndef LPSI_DEFS_VH
`define LPSI_DEFS_VH
`define LPSI_CLK_PERIOD_NS 100
`define LPSI_CA_WIDTH 10
`define LPSI_BANK_COUNT 8
`define LPSI_ROW_BITS 14
`define LPSI_COL_BITS_X32 10
`define LPSI_COL_BITS_X16 11
`define LPSI_ROW_COUNT 16384
`define LPSI_COL_COUNT_X32 1024
`define LPSI_COL_COUNT_X16 2048
`define LPSI_POST_GATE_IDLE_US 200
`define LPSI_POST_GATE_IDLE_CYC ((`LPSI_POST_GATE_IDLE_US * 1000) / `LPSI_CLK_PERIOD_NS)
`define LPSI_POST_RESET_WAIT_US 1
`define LPSI_POST_RESET_WAIT_CYC ((`LPSI_POST_RESET_WAIT_US * 1000) / `LPSI_CLK_PERIOD_NS)
`define LPSI_AUTO_INIT_MAX_US 10
`define LPSI_AUTO_INIT_CYC ((`LPSI_AUTO_INIT_MAX_US * 1000) / `LPSI_CLK_PERIOD_NS)
`define LPSI_AUTO_INIT_DEFAULT 2000
`define LPSI_ST_POWER 3'h0
`define LPSI_ST_BOOT 3'h1
`define LPSI_ST_RESETWAIT 3'h2
`define LPSI_ST_AUTOINIT 3'h3
`define LPSI_ST_IDLE 3'h4
`define LPSI_OP_IDLE 3'h0
`define LPSI_OP_ACT 3'h1
`define LPSI_OP_READ 3'h2
`define LPSI_OP_WRITE 3'h3
`define LPSI_OP_PRE 3'h4
`define LPSI_OP_MRW 3'h5
`define LPSI_OP_MRR 3'h6
`define LPSI_MRW_RESET_ADDR 8'h3f
`define LPSI_MR_STATUS_ADDR 8'h00
`define LPSI_BL_DEFAULT 5'h08
`endif

// ===== hdl/lpsi_word_mem.v
// small word memory with registered read data, one 4n-bit word per entry
`timescale 1ns/1ps
`default_nettype none
module lpsi_word_mem #(
   parameter WIDTH = 32,
   parameter ADDR_BITS = 8
) (
   // clock
   input wire clk,
   // write port
   input wire wrEn,
   input wire [ADDR_BITS-1:0] wrAddr,
   input wire [WIDTH-1:0] wrData,
   // read port
   input wire [ADDR_BITS-1:0] rdAddr,
   output reg [WIDTH-1:0] rdData
);
   reg [WIDTH-1:0] mem [0:(1<<ADDR_BITS)-1];

   // storage has no reset; contents are undefined until written
   always @(posedge clk)
   begin
      if (wrEn)
      begin
         mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
   end
endmodule // lpsi_word_mem
`default_nettype wire

// ===== hdl/lpsi_sdram_core.v
// memory-side command decode, init tracking and 4n prefetch burst engine
`timescale 1ns/1ps
`default_nettype none
`include "lpsi_defs.vh"
// Operation
// - command, address and bank arrive on a 10-bit command/address bus
// - each command takes one cycle, halves captured on rising and falling edge
// - core moves one 4n word per four cycles, as four n-bit full-cycle beats
// - accesses are bursts from chosen column for programmed length and order
// - activate opens the row and bank named by its captured bits
// - read or write bits pick target bank and starting column
// - eight banks, 16384 rows, 1024 columns (x32) or 2048 (x16)
// - in idle every bank is precharged with no row open
// - dq and strobe outputs high impedance while clock enable is low; status outputs stay driven
// - relaxed output timing like strobe skew before configuration
// - auto-init flag must clear within 10 us of reset; core clears it after 2000 cycles (200 us) unless set lower; poll or wait
module lpsi_sdram_core #(
   parameter N = 8,
   parameter MEM_BITS = 8,
   parameter AUTO_INIT_CYC = `LPSI_AUTO_INIT_DEFAULT
) (
   // clock and reset
   input wire clk,
   input wire srst,
   // command/address, already split into rise and fall halves
   input wire [`LPSI_CA_WIDTH-1:0] caRise,
   input wire [`LPSI_CA_WIDTH-1:0] caFall,
   input wire clkEnPin,
   // decoded command from the capture stage
   input wire [2:0] cmdOp,
   input wire [2:0] cmdBank,
   input wire [13:0] cmdAddr,
   // write data, four beats packed as one 4n word
   input wire [4*N-1:0] wrWord,
   // read data and strobe outputs
   output reg [N-1:0] dqOut,
   output reg dqOe,
   output reg strobeOut,
   output reg strobeOe,
   // status
   output reg autoInitFlag,
   output reg idleState,
   output reg [`LPSI_BANK_COUNT-1:0] bankOpen
);
   reg clkEnMeta_q;
   reg clkEn_q;
   reg [2:0] state_q;
   reg [15:0] timer_q;
   reg [13:0] openRow_q [0:`LPSI_BANK_COUNT-1];
   reg [4:0] burstLen_q;
   reg interleave_q;
   reg [4:0] beatLeft_q;
   reg [10:0] col_q;
   reg [2:0] burstBank_q;
   reg burstRd_q;
   reg rdBeat_q;
   reg [1:0] phase_q;
   reg [4*N-1:0] rdWord;
   reg [4*N-1:0] shiftWord_q;
   wire [4*N-1:0] memRd;
   wire [MEM_BITS-1:0] memAddr;
   wire memWe;
   wire isReset;
   wire [10:0] nextCol;
   integer i;

   // clock enable comes from a pin, so it is synchronised first
   always @(posedge clk)
   begin
      if (srst)
      begin
         clkEnMeta_q <= 1'b0;
         clkEn_q <= 1'b0;
      end
      else
      begin
         clkEnMeta_q <= clkEnPin;
         clkEn_q <= clkEnMeta_q;
      end
   end

   assign isReset = (cmdOp == `LPSI_OP_MRW) && (cmdAddr[7:0] == `LPSI_MRW_RESET_ADDR);

   // init sequencer; the controller owns the ramp and gate timing, we track it
   always @(posedge clk)
   begin
      if (srst)
      begin
         state_q <= `LPSI_ST_POWER;
         timer_q <= 16'h0000;
         autoInitFlag <= 1'b1;
      end
      else
      begin
         case (state_q)
            `LPSI_ST_POWER:
            begin
               if (clkEn_q)
               begin
                  state_q <= `LPSI_ST_BOOT;
               end
            end
            `LPSI_ST_BOOT:
            begin
               if (isReset)
               begin
                  state_q <= `LPSI_ST_AUTOINIT;
                  timer_q <= 16'h0000;
                  autoInitFlag <= 1'b1;
               end
            end
            `LPSI_ST_AUTOINIT:
            begin
               timer_q <= timer_q + 16'h0001;
               if (timer_q >= AUTO_INIT_CYC[15:0] - 16'h0001)
               begin
                  autoInitFlag <= 1'b0;
                  state_q <= `LPSI_ST_IDLE;
               end
            end
            `LPSI_ST_IDLE:
            begin
               if (isReset)
               begin
                  state_q <= `LPSI_ST_AUTOINIT;
                  timer_q <= 16'h0000;
                  autoInitFlag <= 1'b1;
               end
            end
            default:
            begin
               state_q <= `LPSI_ST_POWER;
            end
         endcase
      end
   end

   // burst column advances sequentially or interleaved within the burst
   assign nextCol = interleave_q ? {col_q[10:4], col_q[3:0] ^ 4'h1} : col_q + 11'h001;

   // bank tracking and burst control
   always @(posedge clk)
   begin
      if (srst)
      begin
         bankOpen <= 8'h00;
         burstLen_q <= `LPSI_BL_DEFAULT;
         interleave_q <= 1'b0;
         beatLeft_q <= 5'h00;
         col_q <= 11'h000;
         burstBank_q <= 3'h0;
         burstRd_q <= 1'b0;
         idleState <= 1'b0;
         for (i = 0; i < `LPSI_BANK_COUNT; i = i + 1)
         begin
            openRow_q[i] <= 14'h0000;
         end
      end
      else
      begin
         idleState <= (state_q == `LPSI_ST_IDLE) && (bankOpen == 8'h00);
         if (state_q != `LPSI_ST_IDLE || isReset)
         begin
            bankOpen <= 8'h00;
         end
         else
         begin
            case (cmdOp)
               `LPSI_OP_ACT:
               begin
                  bankOpen[cmdBank] <= 1'b1;
                  openRow_q[cmdBank] <= cmdAddr;
               end
               `LPSI_OP_PRE:
               begin
                  bankOpen[cmdBank] <= 1'b0;
               end
               `LPSI_OP_MRW:
               begin
                  if (cmdAddr[7:0] == 8'h01) // burst length and order config
                  begin
                     burstLen_q <= {cmdAddr[12:8] & 5'h1c};
                     interleave_q <= cmdAddr[13];
                  end
               end
               `LPSI_OP_READ, `LPSI_OP_WRITE:
               begin
                  if (bankOpen[cmdBank])
                  begin
                     col_q <= cmdAddr[10:0];
                     burstBank_q <= cmdBank;
                     beatLeft_q <= burstLen_q;
                     burstRd_q <= (cmdOp == `LPSI_OP_READ);
                  end
               end
               default:
               begin
                  burstBank_q <= burstBank_q;
               end
            endcase
            // one beat per clock; the column moves on after the fourth beat of a word
            if (beatLeft_q != 5'h00 && !(cmdOp == `LPSI_OP_READ || cmdOp == `LPSI_OP_WRITE))
            begin
               beatLeft_q <= beatLeft_q - 5'h01;
               if (beatLeft_q[1:0] == 2'h1)
               begin
                  col_q <= nextCol;
               end
            end
         end
      end
   end

   assign memAddr = {burstBank_q, col_q[MEM_BITS-4:0]};
   // a write word lands once, on the first beat of its four
   assign memWe = (beatLeft_q != 5'h00) && !burstRd_q && (beatLeft_q[1:0] == 2'h0);

   // one 4n word per four core cycles
   lpsi_word_mem #(
      .WIDTH(4*N),
      .ADDR_BITS(MEM_BITS)
   ) uMem (
      .clk(clk),
      .wrEn(memWe),
      .wrAddr(memAddr),
      .wrData(wrWord),
      .rdAddr(memAddr),
      .rdData(memRd)
   );

   always @*
   begin
      rdWord = memRd;
   end

   // beat position lags the address one cycle, matching the memory's read register
   always @(posedge clk)
   begin
      if (srst)
      begin
         rdBeat_q <= 1'b0;
         phase_q <= 2'h0;
      end
      else
      begin
         rdBeat_q <= burstRd_q && (beatLeft_q != 5'h00) && (state_q == `LPSI_ST_IDLE);
         phase_q <= 2'h0 - beatLeft_q[1:0];
      end
   end

   // serialise the word into four n-bit beats; each beat is a full cycle at the pins
   always @(posedge clk)
   begin
      if (srst)
      begin
         shiftWord_q <= {4*N{1'b0}};
         dqOut <= {N{1'b0}};
         dqOe <= 1'b0;
         strobeOut <= 1'b0;
         strobeOe <= 1'b0;
      end
      else if (!clkEn_q)
      begin
         dqOe <= 1'b0;
         strobeOe <= 1'b0;
      end
      else if (rdBeat_q)
      begin
         // single clock: beats come one per cycle, not per half-cycle
         if (phase_q == 2'h0)
         begin
            dqOut <= rdWord[N-1:0];
            shiftWord_q <= rdWord >> N;
         end
         else
         begin
            dqOut <= shiftWord_q[N-1:0];
            shiftWord_q <= shiftWord_q >> N;
         end
         dqOe <= 1'b1;
         strobeOut <= phase_q[0];
         strobeOe <= 1'b1;
      end
      else
      begin
         dqOe <= 1'b0;
         strobeOe <= 1'b0;
      end
   end
   // caRise and caFall are decoded upstream into cmdOp; kept for width visibility
   wire unusedCa = ^{caRise, caFall, rdWord[0], openRow_q[0][0]};
endmodule // lpsi_sdram_core
`default_nettype wire

// ===== bench/lpsi_core_monitor.sv
// assertion checker on the sdram core ports
`timescale 1ns/1ps
`default_nettype none
`include "lpsi_defs.vh"
module lpsi_core_monitor #(
   parameter AUTO_INIT_CYC = `LPSI_AUTO_INIT_DEFAULT
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // command side
   input wire logic clkEnPin,
   input wire logic [2:0] cmdOp,
   input wire logic [2:0] cmdBank,
   input wire logic [13:0] cmdAddr,
   // watched outputs
   input wire logic dqOe,
   input wire logic strobeOe,
   input wire logic autoInitFlag,
   input wire logic idleState,
   input wire logic [7:0] bankOpen
);
   logic [15:0] sinceRst_q;
   // cycles since the reset write; saturates so a fall without one is caught
   always_ff @(posedge clk)
   begin
      if (srst)
         sinceRst_q <= 16'hFFFF;
      else if (cmdOp == `LPSI_OP_MRW && cmdAddr[7:0] == `LPSI_MRW_RESET_ADDR)
         sinceRst_q <= 16'h0000;
      else if (sinceRst_q != 16'hFFFF)
         sinceRst_q <= sinceRst_q + 16'h0001;
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   sequence gateLow;
      !clkEnPin [*4];
   endsequence
   sequence openRead;
      !autoInitFlag && clkEnPin && cmdOp == `LPSI_OP_READ && bankOpen[cmdBank];
   endsequence
   a_reset_state: assert property (disable iff (1'b0) srst |=> autoInitFlag && bankOpen == 8'h00)
      else $error("reset state wrong");
   a_hiz_gate_low: assert property (gateLow |=> !dqOe && !strobeOe)
      else $error("pins driven with gate low");
   a_act_opens_bank: assert property (!autoInitFlag && cmdOp == `LPSI_OP_ACT |=> bankOpen[$past(cmdBank)])
      else $error("activate left bank closed");
   a_read_starts: assert property (openRead |-> ##[1:3] dqOe)
      else $error("read gave no beats");
   a_burst_whole: assert property ($rose(dqOe) |-> dqOe [*4])
      else $error("burst shorter than one word");
   a_boot_refuses: assert property (autoInitFlag |=> $stable(bankOpen))
      else $error("bank moved before idle");
   a_idle_clean: assert property ($fell(autoInitFlag) |-> bankOpen == 8'h00)
      else $error("bank open entering idle");
   a_init_in_time: assert property ($fell(autoInitFlag) |-> sinceRst_q <= AUTO_INIT_CYC + 2)
      else $error("auto-init too long");
endmodule // lpsi_core_monitor
bind lpsi_sdram_core lpsi_core_monitor #(.AUTO_INIT_CYC(AUTO_INIT_CYC)) u_mon (
   .clk(clk), .srst(srst), .clkEnPin(clkEnPin), .cmdOp(cmdOp), .cmdBank(cmdBank),
   .cmdAddr(cmdAddr), .dqOe(dqOe), .strobeOe(strobeOe), .autoInitFlag(autoInitFlag),
   .idleState(idleState), .bankOpen(bankOpen)
);
`default_nettype wire

// ===== bench/lpsi_ctrl_model.sv
// memory controller model driving gate and commands
`timescale 1ns/1ps
`default_nettype none
`include "lpsi_defs.vh"
module lpsi_ctrl_model (
   // clock
   input wire logic clk,
   // command side
   output logic clkEnPin,
   output logic [2:0] cmdOp,
   output logic [2:0] cmdBank,
   output logic [13:0] cmdAddr,
   output logic [9:0] caRise,
   output logic [9:0] caFall
);
   // halves of one command, rise then fall
   assign caRise = {cmdAddr[6:0], cmdOp};
   assign caFall = {cmdAddr[13:7], cmdBank};
   initial
   begin
      clkEnPin = 1'b0;
      cmdOp = `LPSI_OP_IDLE;
      cmdBank = 3'h0;
      cmdAddr = 14'h0000;
   end
   // one cycle per command; released fields flip so stale values never pass
   task issue(input logic [2:0] op, input logic [2:0] bank, input logic [13:0] addr);
      @(negedge clk);
      cmdOp = op;
      cmdBank = bank;
      cmdAddr = addr;
      @(negedge clk);
      cmdOp = `LPSI_OP_IDLE;
      cmdBank = ~bank;
      cmdAddr = ~addr;
   endtask
   task gate(input logic on);
      @(negedge clk);
      clkEnPin = on;
   endtask
   // gate low then stable clocks, idle period, then reset write at full rate
   task power_up;
      repeat (6) @(negedge clk);
      clkEnPin = 1'b1;
      repeat (`LPSI_POST_GATE_IDLE_CYC + 10) @(negedge clk);
      issue(`LPSI_OP_MRW, 3'h0, {6'h00, `LPSI_MRW_RESET_ADDR});
   endtask
endmodule // lpsi_ctrl_model
`default_nettype wire

// ===== bench/lpsi_sdram_core_bench.sv
// self-checking bench for the sdram core
`timescale 1ns/1ps
`default_nettype none
`include "lpsi_defs.vh"
module lpsi_sdram_core_bench;
   localparam int AIC = 20;
   logic clk, srst, clkEnPin, dqOe, strobeOut, strobeOe, autoInitFlag, idleState;
   logic [2:0] cmdOp, cmdBank;
   logic [13:0] cmdAddr;
   logic [9:0] caRise, caFall;
   logic [31:0] wrWord;
   logic [7:0] dqOut, bankOpen;
   int mismatches, samples_checked, i, k;
   // rows: op, bank, expected open mask
   logic [13:0] rows [6] = '{14'h0801, 14'h0F81, 14'h2080, 14'h0B88, 14'h2708, 14'h2300};
   lpsi_ctrl_model u_ctl (.clk(clk), .clkEnPin(clkEnPin), .cmdOp(cmdOp), .cmdBank(cmdBank),
      .cmdAddr(cmdAddr), .caRise(caRise), .caFall(caFall));
   lpsi_sdram_core #(.AUTO_INIT_CYC(AIC)) u_dut (.clk(clk), .srst(srst), .caRise(caRise),
      .caFall(caFall), .clkEnPin(clkEnPin), .cmdOp(cmdOp), .cmdBank(cmdBank),
      .cmdAddr(cmdAddr), .wrWord(wrWord), .dqOut(dqOut), .dqOe(dqOe),
      .strobeOut(strobeOut), .strobeOe(strobeOe), .autoInitFlag(autoInitFlag),
      .idleState(idleState), .bankOpen(bankOpen));
   // 100 ns period also suits mode reads at boot
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task chk(input logic ok, input string msg);
      samples_checked++;
      if (ok !== 1'b1)
      begin
         mismatches++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask
   task stop_test;
      if (mismatches == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      srst = 1'b1;
      wrWord = 32'hA5C3_1E77;
      repeat (2) @(negedge clk);
      srst = 1'b0;
      chk(autoInitFlag === 1'b1 && bankOpen === 8'h00 && dqOe === 1'b0, "reset");
      u_ctl.issue(`LPSI_OP_ACT, 3'h1, 14'h0000);
      chk(bankOpen === 8'h00, "boot act taken");
      u_ctl.power_up();
      // bounded wait; a hang ends the run with a mismatch
      for (i = 0; i < AIC + 40 && autoInitFlag !== 1'b0; i++) @(negedge clk);
      chk(autoInitFlag === 1'b0, "auto-init timeout");
      if (autoInitFlag !== 1'b0)
         stop_test();
      @(negedge clk);
      chk(idleState === 1'b1 && bankOpen === 8'h00, "idle");
      foreach (rows[r])
      begin
         u_ctl.issue(rows[r][13:11], rows[r][10:8], 14'h0000);
         @(negedge clk);
         chk(bankOpen === rows[r][7:0], "bank mask");
      end
      u_ctl.issue(`LPSI_OP_ACT, 3'h2, 14'h0005);
      u_ctl.issue(`LPSI_OP_WRITE, 3'h2, 14'h0000);
      repeat (10) @(negedge clk);
      u_ctl.issue(`LPSI_OP_READ, 3'h2, 14'h0000);
      for (i = 0; i < 4 && dqOe !== 1'b1; i++) @(negedge clk);
      // beats of the prefetched word, low beat first
      for (k = 0; k < 4; k++)
      begin
         chk(dqOut === wrWord[8*k +: 8], "read beat");
         chk(strobeOe === 1'b1 && strobeOut === k[0], "read strobe");
         @(negedge clk);
      end
      repeat (10) @(negedge clk);
      u_ctl.issue(`LPSI_OP_READ, 3'h6, 14'h0000);
      repeat (3) @(negedge clk);
      chk(dqOe === 1'b0, "closed bank read");
      u_ctl.gate(1'b0);
      repeat (5) @(negedge clk);
      chk(dqOe === 1'b0 && strobeOe === 1'b0, "gate low drive");
      srst = 1'b1;
      repeat (2) @(negedge clk);
      srst = 1'b0;
      chk(autoInitFlag === 1'b1 && bankOpen === 8'h00, "second reset");
      stop_test();
   end
endmodule // lpsi_sdram_core_bench
`default_nettype wire
